// >>> rtl/asq_decoder.sv
// Serial command decoder holding the sequence-length register
// Operation
// - Words with bits 15:11 equal to 10110 write the sequence-length register.
// - Bits 10:3 hold count minus one; zero means one, all ones means 256.
// - A word with MSB 1 is configuration data.
// - A word with MSB 0 is a mode-control instruction starting conversions.
// - Mode-control during a sequence waits for current conversion, runs at next chip-select fall.
// - Configuration during a sequence finishes current conversion in the old scan mode.
// - After configuration mid-sequence, output is invalid until a new mode-control word.
`timescale 1ns/10ps
`include "asq_params.svh"
module asq_decoder #(
	parameter logic [15:0] CONV_CYCLES = `ASQ_CONV_CYCLES
) (
	input  wire logic               clk_sys,
	input  wire logic               arst_n,
	input  wire logic               cs_n,
	input  wire logic               sclk,
	input  wire logic               din,
	output asq_pkg::asq_count_t     sequence_count_field,
	output logic [8:0]              sequence_length,
	output asq_pkg::asq_word_t      config_word,
	output logic                    config_valid,
	output asq_pkg::asq_word_t      mode_word,
	output logic                    mode_start,
	output logic                    busy,
	output logic                    conv_done,
	output logic                    dout_valid
);
	import asq_pkg::*;

	typedef enum logic [1:0] {ASQ_IDLE, ASQ_CONV, ASQ_HOLD} asq_state_e;

	logic [2:0]               pins_s;
	logic                     sclk_d_reg;
	logic                     cs_d_reg;
	asq_word_t                shift_reg;
	logic [`ASQ_BIT_CNT_W-1:0] bit_cnt_reg;
	logic                     word_stb;
	asq_word_t                word;
	logic                     sclk_rise;
	logic                     cs_fall;
	logic                     pend_mode_reg;
	asq_word_t                pend_word_reg;
	logic [15:0]              conv_cnt_reg;
	logic [8:0]               seq_left_reg;
	asq_state_e               state_reg;
	logic                     is_mode;
	logic                     last_conv;

	asq_sync #(.W(3)) u_sync (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		// Select goes in inverted so the flops' reset value reads as an idle, deselected link
		.d       ({~cs_n, sclk, din}),
		.q       (pins_s)
	);

	assign sclk_rise = pins_s[1] && !sclk_d_reg && pins_s[2];
	assign cs_fall   = pins_s[2] && !cs_d_reg;
	assign word      = {shift_reg[`ASQ_WORD_W-2:0], pins_s[0]};
	assign word_stb  = sclk_rise && (bit_cnt_reg == 5'(`ASQ_WORD_W - 1));
	assign is_mode   = !word[`ASQ_WORD_W-1];
	assign last_conv = (conv_cnt_reg == CONV_CYCLES - 16'h0001);

	// Edge detection on synchronised pins only
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sclk_d_reg <= 1'b0;
			cs_d_reg   <= 1'b0;
		end else begin
			sclk_d_reg <= pins_s[1];
			cs_d_reg   <= pins_s[2];
		end
	end

	// Shifter; a frame restarts on every chip-select fall
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg   <= '0;
			bit_cnt_reg <= '0;
		end else if (!pins_s[2] || cs_fall) begin
			bit_cnt_reg <= '0;
		end else if (sclk_rise && bit_cnt_reg != 5'(`ASQ_WORD_W)) begin
			// Count stops past a full word so extra link clocks cannot strobe a second word
			shift_reg   <= word;
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// Sequence-length register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sequence_count_field <= `ASQ_CNT_RESET;
		end else if (word_stb && word[`ASQ_WORD_W-1]
		             && word[`ASQ_SEL_HI:`ASQ_SEL_LO] == `ASQ_SEL_SEQ) begin
			sequence_count_field <= word[`ASQ_CNT_HI:`ASQ_CNT_LO];
		end
	end
	assign sequence_length = {1'b0, sequence_count_field} + 9'h001;

	// Configuration output; the running conversion keeps its latched scan mode
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			config_word  <= '0;
			config_valid <= 1'b0;
		end else begin
			config_valid <= word_stb && !is_mode;
			if (word_stb && !is_mode) begin
				config_word <= word;
			end
		end
	end

	// Pending mode instruction, taken at the next chip-select fall outside a conversion
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pend_mode_reg <= 1'b0;
			pend_word_reg <= '0;
		end else if (word_stb && is_mode) begin
			pend_mode_reg <= 1'b1;
			pend_word_reg <= word;
		end else if (cs_fall && state_reg != ASQ_CONV) begin
			pend_mode_reg <= 1'b0;
		end
	end

	// Conversion sequencer
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg    <= ASQ_IDLE;
			conv_cnt_reg <= '0;
			seq_left_reg <= '0;
			mode_word    <= '0;
			mode_start   <= 1'b0;
			conv_done    <= 1'b0;
		end else begin
			mode_start <= 1'b0;
			conv_done  <= 1'b0;
			unique case (state_reg)
				ASQ_IDLE, ASQ_HOLD: begin
					if (pend_mode_reg && cs_fall) begin
						mode_word    <= pend_word_reg;
						mode_start   <= 1'b1;
						seq_left_reg <= sequence_length;
						conv_cnt_reg <= '0;
						state_reg    <= ASQ_CONV;
					end else if (state_reg == ASQ_HOLD && !pend_mode_reg) begin
						state_reg <= ASQ_IDLE;
					end
				end
				ASQ_CONV: begin
					conv_cnt_reg <= last_conv ? 16'h0000 : conv_cnt_reg + 16'h0001;
					if (last_conv) begin
						conv_done    <= 1'b1;
						seq_left_reg <= seq_left_reg - 9'h001;
						// New instruction preempts only at a conversion boundary
						if (pend_mode_reg || seq_left_reg == 9'h001) begin
							state_reg <= ASQ_HOLD;
						end
					end
				end
				default: state_reg <= ASQ_IDLE;
			endcase
		end
	end
	assign busy = (state_reg == ASQ_CONV);

	// Output validity lost by a mid-sequence configuration write
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dout_valid <= 1'b1;
		end else if (word_stb && is_mode) begin
			dout_valid <= 1'b1;
		end else if (word_stb && busy) begin
			dout_valid <= 1'b0;
		end
	end

	AST_SEQ_WRITE: assert property (@(posedge clk_sys) disable iff (!arst_n)
		word_stb && word[`ASQ_SEL_HI:`ASQ_SEL_LO] == `ASQ_SEL_SEQ
		|=> sequence_count_field == $past(word[`ASQ_CNT_HI:`ASQ_CNT_LO]))
		else $error("sequence length not stored");

	AST_LEN: assert property (@(posedge clk_sys) disable iff (!arst_n)
		sequence_length[8] == (sequence_count_field == 8'hFF)
		&& sequence_length[7:0] == sequence_count_field + 8'h01)
		else $error("length mismatch");

	AST_RESTART: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cs_fall |=> bit_cnt_reg == '0)
		else $error("frame not restarted on select");

	AST_CFG: assert property (@(posedge clk_sys) disable iff (!arst_n)
		word_stb && word[`ASQ_WORD_W-1] |=> config_valid && config_word == $past(word))
		else $error("config not taken");

	AST_MODE_PEND: assert property (@(posedge clk_sys) disable iff (!arst_n)
		word_stb && !word[`ASQ_WORD_W-1] |=> pend_mode_reg && !config_valid)
		else $error("mode word not pending");

	sequence s_conv_end;
		busy && last_conv && pend_mode_reg;
	endsequence
	AST_PREEMPT: assert property (@(posedge clk_sys) disable iff (!arst_n)
		s_conv_end |=> !busy && !mode_start)
		else $error("preempt not at conversion boundary");

	AST_NO_EARLY: assert property (@(posedge clk_sys) disable iff (!arst_n)
		busy && !last_conv |=> busy)
		else $error("conversion cut short");

	AST_START_CS: assert property (@(posedge clk_sys) disable iff (!arst_n)
		mode_start |-> $past(cs_fall) && $past(pend_mode_reg))
		else $error("start without chip-select fall");

	AST_KEEP_MODE: assert property (@(posedge clk_sys) disable iff (!arst_n)
		busy && $past(busy) && !mode_start |-> $stable(mode_word))
		else $error("mode changed mid conversion");

	AST_INVALID: assert property (@(posedge clk_sys) disable iff (!arst_n)
		word_stb && word[`ASQ_WORD_W-1] && busy |=> !dout_valid)
		else $error("output not invalidated");
endmodule : asq_decoder

// >>> rtl/asq_params.svh
// Constants for the sequence-programming command decoder
`ifndef ASQ_PARAMS_SVH
`define ASQ_PARAMS_SVH
`define ASQ_WORD_W        16
`define ASQ_SEL_HI        15
`define ASQ_SEL_LO        11
`define ASQ_SEL_SEQ       5'h16
`define ASQ_CNT_HI        10
`define ASQ_CNT_LO        3
`define ASQ_CNT_RESET     8'h00
`define ASQ_BIT_CNT_W     5
`define ASQ_CONV_CYCLES   16'h0020
`endif

// >>> rtl/asq_pkg.sv
// Types for the sequence-programming command decoder
`include "asq_params.svh"
package asq_pkg;
	typedef logic [`ASQ_WORD_W-1:0] asq_word_t;
	typedef logic [7:0]             asq_count_t;
endpackage : asq_pkg

// >>> rtl/asq_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module asq_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : asq_sync

// >>> tb/asq_host.sv
// Serial host model for the command decoder
`timescale 1ns/10ps
module asq_host (
	output logic cs_n,
	output logic sclk,
	output logic din
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end
	// MSB first, data set while the link clock is low
	task automatic send(input logic [15:0] w);
		// Keeps pin changes off the system clock edge
		#2;
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			din = w[i];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		din = ~din; // Released line must not hold its last bit
		#250;
	endtask : send
	// Empty frame: only the chip-select fall matters
	task automatic strobe();
		#2;
		cs_n = 1'b0;
		#250 cs_n = 1'b1;
		#250;
	endtask : strobe
endmodule : asq_host

// >>> tb/testbench.sv
// Self-checking bench for the command decoder
`timescale 1ns/10ps
module testbench;
	import asq_pkg::*;
	logic       clk_sys;
	logic       arst_n;
	logic       cs_n;
	logic       sclk;
	logic       din;
	asq_count_t sequence_count_field;
	logic [8:0] sequence_length;
	asq_word_t  config_word;
	logic       config_valid;
	asq_word_t  mode_word;
	logic       mode_start;
	logic       busy;
	logic       conv_done;
	logic       dout_valid;
	int         mismatches;
	int         n_checks;
	int         n_conv;
	int         n_start;
	int         cycles;
	int         n_cfg;
	asq_host u_host (.cs_n(cs_n), .sclk(sclk), .din(din));
	asq_decoder u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n),
		.sclk(sclk), .din(din), .sequence_count_field(sequence_count_field),
		.sequence_length(sequence_length), .config_word(config_word), .config_valid(config_valid),
		.mode_word(mode_word), .mode_start(mode_start), .busy(busy), .conv_done(conv_done),
		.dout_valid(dout_valid));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (conv_done === 1'b1) n_conv++;
		if (mode_start === 1'b1) n_start++;
		if (config_valid === 1'b1) n_cfg++;
		if (cycles == 10000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Falling-edge sampling so outputs launched on the rising edge have settled
	task automatic wait_busy(input logic lvl, input int limit);
		for (int i = 0; i < limit && busy !== lvl; i++) @(negedge clk_sys);
		repeat (2) @(negedge clk_sys);
	endtask : wait_busy
	task automatic t_length();
		logic [7:0] v [4] = '{8'h00, 8'hFF, 8'h5A, 8'h01};
		int         c;
		c = n_cfg;
		foreach (v[i]) begin
			u_host.send({5'h16, v[i], 3'h7});
			check(sequence_count_field, v[i]);
			check(sequence_length, v[i] + 9'h001);
		end
		u_host.send(16'hA3F8);
		check(sequence_count_field, 16'h0001);
		check(config_word, 16'hA3F8);
		check(n_cfg - c, 16'h0005);
		$display("test length done");
	endtask : t_length
	task automatic t_mode();
		int s;
		int st;
		int c;
		s  = n_conv;
		st = n_start;
		c  = n_cfg;
		u_host.send(16'h0800);
		check(busy, 16'h0000);
		check(n_cfg - c, 16'h0000);
		u_host.strobe();
		wait_busy(1'b0, 200);
		check(n_start - st, 16'h0001);
		check(mode_word, 16'h0800);
		check(n_conv - s, 16'h0002);
		$display("test mode done");
	endtask : t_mode
	// Long sequence so both mid-run words land while it runs
	task automatic t_mid();
		int s;
		int c;
		u_host.send({5'h16, 8'hFF, 3'h0});
		u_host.send(16'h0800);
		u_host.strobe();
		check(busy, 16'h0001);
		c = n_conv;
		u_host.send(16'hA000);
		check(busy, 16'h0001);
		check(mode_word, 16'h0800);
		check(dout_valid, 16'h0000);
		u_host.send(16'h0810);
		wait_busy(1'b0, 64);
		check(busy, 16'h0000);
		check(n_conv - c < 256, 16'h0001);
		check(dout_valid, 16'h0001);
		s = n_start;
		u_host.strobe();
		wait_busy(1'b1, 64);
		check(n_start - s, 16'h0001);
		check(mode_word, 16'h0810);
		check(busy, 16'h0001);
		$display("test mid-sequence done");
	endtask : t_mid
	// Reset lands in the middle of a running sequence
	task automatic t_reset();
		@(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (3) @(negedge clk_sys);
		check(busy, 16'h0000);
		check(sequence_length, 16'h0001);
		check(dout_valid, 16'h0001);
		check(config_valid, 16'h0000);
		@(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(negedge clk_sys);
		u_host.send({5'h16, 8'h03, 3'h5});
		check(sequence_length, 16'h0004);
		check(busy, 16'h0000);
		$display("test reset done");
	endtask : t_reset
	initial begin
		arst_n <= 1'b0;
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (4) @(negedge clk_sys);
		check(sequence_length, 16'h0001);
		check(dout_valid, 16'h0001);
		t_length();
		t_mode();
		t_mid();
		t_reset();
		close_out();
	end
endmodule : testbench
